// >>> conn_pkg.sv
// shared types and constants for the network transport connection block
package conn_pkg;

    // =========================================================
    // connection states, gray coded along the usual path
    typedef enum logic [2:0] {
        state_idle_unlinked = 3'h0,
        state_passive_wait = 3'h1,
        state_active_open = 3'h3,
        state_linked = 3'h2,
        state_teardown = 3'h6
    } conn_state_t;

    // =========================================================
    // socket operations issued to the tcp/ip engine
    typedef enum logic [3:0] {
        op_none = 4'h0,
        op_socket = 4'h1,
        op_bind = 4'h2,
        op_listen = 4'h3,
        op_accept = 4'h4,
        op_connect = 4'h5,
        op_send = 4'h6,
        op_recv = 4'h7,
        op_shutdown = 4'h8,
        op_close = 4'h9
    } sock_op_t;

    // =========================================================
    // service requests from the upper port layer
    typedef enum logic [2:0] {
        req_listen = 3'h0,
        req_connect = 3'h1,
        req_send = 3'h2,
        req_recv = 3'h3,
        req_disc = 3'h4
    } upper_req_t;

    // =========================================================
    // widths, steps and timing
    localparam int CHAR_W = 8;
    localparam int TMO_W = 32;
    localparam logic [2:0] STEP_FIRST = 3'h0;
    localparam int CLK_HZ = 100_000_000;
    localparam int ACK_TMO_MS = 2500;
    localparam int ACK_TMO_CYC = ACK_TMO_MS * (CLK_HZ / 1000);
    localparam logic [TMO_W-1:0] TMO_ZERO = 32'h0000_0000;
    localparam logic [TMO_W-1:0] TMO_ONE = 32'h0000_0001;
    localparam logic [1:0] BUF_FULL = 2'h2;

endpackage : conn_pkg

// >>> two_entry_buffer.sv
// two-entry buffer carrying received characters to the upper layer
`timescale 1ns/100ps
module two_entry_buffer (
    input logic clk_in,
    input logic rst_in,
    input logic in_valid_in,
    output logic in_ready_out,
    input logic [conn_pkg::CHAR_W-1:0] in_data_in,
    output logic out_valid_out,
    input logic out_ready_in,
    output logic [conn_pkg::CHAR_W-1:0] out_data_out
);
    import conn_pkg::*;

    typedef struct packed {
        logic [1:0][CHAR_W-1:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } buf_t;

    buf_t r;
    buf_t n;
    logic push;
    logic pop;

    // =========================================================
    // handshakes: full refuses, empty shows nothing
    assign in_ready_out = (r.cnt != BUF_FULL);
    assign out_valid_out = (r.cnt != 2'h0);
    assign out_data_out = r.mem[r.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // next state: write at wr, read at rd, count follows both
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr] = in_data_in;
            n.wr = ~r.wr;
        end
        if (pop) begin
            n.rd = ~r.rd;
        end
        n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule : two_entry_buffer

// >>> ack_timer.sv
// acknowledgement time-out timer for transmitted frames
`timescale 1ns/100ps
module ack_timer #(
    parameter logic [conn_pkg::TMO_W-1:0] INIT_CYC = 32'h0ee6_b280
) (
    input logic clk_in,
    input logic rst_in,
    input logic load_in,
    input logic [conn_pkg::TMO_W-1:0] load_val_in,
    input logic frame_tx_in,
    input logic ack_rx_in,
    output logic expired_out,
    output logic [conn_pkg::TMO_W-1:0] tmo_out
);
    import conn_pkg::*;

    typedef struct packed {
        logic [TMO_W-1:0] tmo;
        logic [TMO_W-1:0] cnt;
        logic run;
        logic exp;
    } tmr_t;

    tmr_t r;
    tmr_t n;

    assign expired_out = r.exp;
    assign tmo_out = r.tmo;

    // =========================================================
    // a new period only affects frames started after the load;
    // a frame already running keeps the period it started with
    always_comb begin
        n = r;
        n.exp = 1'b0;
        if (load_in) begin
            n.tmo = (load_val_in == TMO_ZERO) ? TMO_ONE : load_val_in;
        end
        if (frame_tx_in) begin
            n.cnt = r.tmo;
            n.run = 1'b1;
        end else if (ack_rx_in) begin
            n.run = 1'b0;
        end else if (r.run) begin
            n.cnt = r.cnt - TMO_ONE;
            if (r.cnt == TMO_ONE) begin
                n.run = 1'b0;
                n.exp = 1'b1;
            end
        end
    end

    // reset restores the initial network period
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '{tmo: INIT_CYC, cnt: TMO_ZERO, run: 1'b0, exp: 1'b0};
        end else begin
            r <= n;
        end
    end

endmodule : ack_timer

// >>> network_transport_port.sv
// connection state machine of a network transport port
// Function
// - hard reset starts in not-connected state
// - returning to not-connected closes the socket
// - not connected: only opens accepted, rest refused
// - passive open from idle enters listening
// - active open from idle enters connecting
// - listening entry: socket, bind, listen, accept
// - listening: connect and teardown accepted, others refused
// - accept success: connected, link-up confirmation
// - teardown while listening: accept fails, link-down
// - connect while listening: close, then connecting
// - connecting entry: socket, bind, connect
// - connecting: only teardown accepted, others refused
// - teardown or connect failure: idle, link-down
// - connect success: connected, link-up confirmation
// - connected: send, receive, teardown; refuse opens
// - teardown when connected enters disconnecting, shutdown
// - remote teardown when connected returns to idle
// - disconnecting: only fetches served, rest refused
// - receive failure while disconnecting: idle, link-down
// - abort login, reset ack, sense loss, reset: nexus
// - parameter change loads new ack time-out
// - initial ack time-out is 2.5 seconds
`timescale 1ns/100ps
module network_transport_port #(
    parameter int ACK_TMO_CYCLES = conn_pkg::ACK_TMO_CYC
) (
    input logic clk_in,
    input logic rst_in,
    input logic req_valid_in,
    input conn_pkg::upper_req_t req_kind_in,
    input logic [conn_pkg::CHAR_W-1:0] req_char_in,
    output logic req_ready_out,
    output logic req_accept_out,
    output logic req_reject_out,
    output logic link_up_out,
    output logic link_down_out,
    output logic rx_valid_out,
    input logic rx_ready_in,
    output logic [conn_pkg::CHAR_W-1:0] rx_char_out,
    output logic op_req_out,
    output conn_pkg::sock_op_t op_code_out,
    output logic [conn_pkg::CHAR_W-1:0] op_data_out,
    output logic op_cancel_out,
    input logic op_ack_in,
    input logic op_ok_in,
    input logic [conn_pkg::CHAR_W-1:0] op_rdata_in,
    input logic remote_close_in,
    input logic remote_conn_in,
    output logic remote_reject_out,
    input logic login_sent_abort_in,
    input logic login_rcvd_abort_in,
    input logic reset_unit_ack_in,
    input logic presence_in,
    input logic reset_line_in,
    output logic nexus_loss_out,
    input logic param_change_in,
    input logic [conn_pkg::TMO_W-1:0] param_tmo_in,
    input logic tmo_unit_in,
    input logic [conn_pkg::TMO_W-1:0] tmo_unit_val_in,
    input logic frame_tx_in,
    input logic ack_rx_in,
    output logic ack_expired_out,
    output conn_pkg::conn_state_t state_out
);
    import conn_pkg::*;

    // =========================================================
    // state record
    typedef struct packed {
        conn_state_t st;
        logic [2:0] step;
        logic busy;
        sock_op_t op;
        logic [CHAR_W-1:0] odata;
        logic close_pend;
        logic go_active;
        logic cancel;
        logic up;
        logic down;
        logic acc;
        logic rej;
        logic rrej;
        logic nexus;
        logic pres_m;
        logic pres_s;
        logic pres_d;
        logic rline_m;
        logic rline_s;
        logic rline_d;
    } ctl_t;

    localparam ctl_t CTL_RST = '0;

    ctl_t r;
    ctl_t n;
    logic take;
    logic legal;
    logic push;
    logic buf_rdy;
    logic tmo_load;
    logic [TMO_W-1:0] tmo_val;
    sock_op_t seq;

    // =========================================================
    // opening, close and shutdown sequences issued one operation at a time
    function automatic sock_op_t seq_op(conn_state_t st,
                                        logic [2:0] step,
                                        logic cp);
        sock_op_t o;
        o = op_none;
        unique case (st)
            state_idle_unlinked: begin
                if (cp) begin
                    o = op_close;
                end
            end
            state_passive_wait: begin
                unique case (step)
                    3'h0: o = op_socket;
                    3'h1: o = op_bind;
                    3'h2: o = op_listen;
                    3'h3: o = op_accept;
                    default: o = op_none;
                endcase
            end
            state_active_open: begin
                unique case (step)
                    3'h0: o = op_socket;
                    3'h1: o = op_bind;
                    3'h2: o = op_connect;
                    default: o = op_none;
                endcase
            end
            state_teardown: begin
                if (step == STEP_FIRST) begin
                    o = op_shutdown;
                end
            end
            state_linked: o = op_none;
            default: o = op_none;
        endcase
        return o;
    endfunction : seq_op

    // which requests each state accepts; everything else is refused
    function automatic logic req_ok(conn_state_t st, upper_req_t k);
        logic ok;
        ok = 1'b0;
        unique case (st)
            state_idle_unlinked: ok = (k == req_listen) || (k == req_connect);
            state_passive_wait: ok = (k == req_connect) || (k == req_disc);
            state_active_open: ok = (k == req_disc);
            state_linked: ok = (k != req_listen) && (k != req_connect);
            state_teardown: ok = (k == req_recv);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : req_ok

    // =========================================================
    // request handshake: refusals are taken at once, accepted ones
    // wait until the engine is in the matching phase
    always_comb begin
        legal = req_ok(r.st, req_kind_in);
        req_ready_out = 1'b1;
        if (legal) begin
            unique case (r.st)
                state_idle_unlinked: req_ready_out = !r.busy && !r.close_pend;
                state_passive_wait: req_ready_out = r.busy && !op_ack_in
                    && (r.op == op_accept) && !r.go_active;
                state_active_open: req_ready_out = r.busy && !op_ack_in
                    && (r.op == op_connect);
                state_linked: req_ready_out = !r.busy
                    && ((req_kind_in != req_recv) || buf_rdy);
                state_teardown: req_ready_out = !r.busy
                    && (r.step != STEP_FIRST) && buf_rdy;
                default: req_ready_out = 1'b1;
            endcase
        end
    end

    assign take = req_valid_in && req_ready_out;
    assign seq = seq_op(r.st, r.step, r.close_pend);

    // =========================================================
    // next state
    always_comb begin
        n = r;
        push = 1'b0;
        n.up = 1'b0;
        n.down = 1'b0;
        n.acc = 1'b0;
        n.rej = 1'b0;
        n.cancel = 1'b0;
        // first stage feeds only the second stage
        n.pres_m = presence_in;
        n.pres_s = r.pres_m;
        n.pres_d = r.pres_s;
        n.rline_m = reset_line_in;
        n.rline_s = r.rline_m;
        n.rline_d = r.rline_s;
        n.nexus = login_sent_abort_in || login_rcvd_abort_in
            || reset_unit_ack_in || (r.pres_d && !r.pres_s)
            || (r.rline_s && !r.rline_d);
        n.rrej = remote_conn_in && (r.st != state_passive_wait);
        // completion of the outstanding socket operation
        if (r.busy && op_ack_in) begin
            n.busy = 1'b0;
            n.op = op_none;
            unique case (r.op)
                op_accept: begin
                    if (r.go_active) begin
                        n.busy = 1'b1;
                        n.op = op_close;
                    end else if (op_ok_in) begin
                        n.st = state_linked;
                        n.up = 1'b1;
                    end else begin
                        n.st = state_idle_unlinked;
                        n.down = 1'b1;
                        n.close_pend = 1'b1;
                    end
                end
                op_connect: begin
                    if (op_ok_in) begin
                        n.st = state_linked;
                        n.up = 1'b1;
                    end else begin
                        n.st = state_idle_unlinked;
                        n.down = 1'b1;
                        n.close_pend = 1'b1;
                    end
                end
                op_close: begin
                    if (r.st == state_passive_wait) begin
                        n.st = state_active_open;
                        n.step = STEP_FIRST;
                        n.go_active = 1'b0;
                    end else begin
                        n.close_pend = 1'b0;
                    end
                end
                op_recv: begin
                    if (op_ok_in) begin
                        // characters outside a connection are dropped
                        push = (r.st == state_linked)
                            || (r.st == state_teardown);
                    end else if (r.st == state_teardown) begin
                        n.st = state_idle_unlinked;
                        n.down = 1'b1;
                        n.close_pend = 1'b1;
                    end
                end
                op_socket, op_bind, op_listen: begin
                    // a failed setup step abandons the attempt
                    if (!op_ok_in) begin
                        n.st = state_idle_unlinked;
                        n.down = 1'b1;
                        n.close_pend = 1'b1;
                    end
                end
                op_send, op_shutdown, op_none: begin
                    n.op = op_none;
                end
                default: n.op = op_none;
            endcase
        end else if (!r.busy && (seq != op_none)) begin
            n.busy = 1'b1;
            n.op = seq;
            n.step = r.step + 3'h1;
        end
        // requests from the upper layer
        if (take && !legal) begin
            n.rej = 1'b1;
        end else if (take) begin
            n.acc = 1'b1;
            unique case (req_kind_in)
                req_listen: begin
                    n.st = state_passive_wait;
                    n.step = STEP_FIRST;
                end
                req_connect: begin
                    if (r.st == state_passive_wait) begin
                        n.go_active = 1'b1;
                        n.cancel = 1'b1;
                    end else begin
                        n.st = state_active_open;
                        n.step = STEP_FIRST;
                    end
                end
                req_send: begin
                    n.busy = 1'b1;
                    n.op = op_send;
                    n.odata = req_char_in;
                end
                req_recv: begin
                    n.busy = 1'b1;
                    n.op = op_recv;
                end
                req_disc: begin
                    if (r.st == state_linked) begin
                        n.st = state_teardown;
                        n.step = STEP_FIRST;
                    end else begin
                        // the engine fails the pending accept or connect
                        n.cancel = 1'b1;
                    end
                end
                default: n.acc = 1'b0;
            endcase
        end
        // the peer tearing down overrides a local request
        if (remote_close_in && (r.st == state_linked)) begin
            n.st = state_idle_unlinked;
            n.close_pend = 1'b1;
        end
    end

    // synchronous reset puts the machine in the unlinked state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= CTL_RST;
        end else begin
            r <= n;
        end
    end

    // =========================================================
    // outputs
    assign req_accept_out = r.acc;
    assign req_reject_out = r.rej;
    assign link_up_out = r.up;
    assign link_down_out = r.down;
    assign op_req_out = r.busy;
    assign op_code_out = r.op;
    assign op_data_out = r.odata;
    assign op_cancel_out = r.cancel;
    assign remote_reject_out = r.rrej;
    assign nexus_loss_out = r.nexus;
    assign state_out = r.st;

    // =========================================================
    // receive path; a recv is only issued while there is room
    two_entry_buffer u_rx_buf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(push),
        .in_ready_out(buf_rdy),
        .in_data_in(op_rdata_in),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in),
        .out_data_out(rx_char_out)
    );

    // either source may replace the period
    assign tmo_load = param_change_in || tmo_unit_in;
    assign tmo_val = param_change_in ? param_tmo_in : tmo_unit_val_in;

    ack_timer #(
        .INIT_CYC(TMO_W'(ACK_TMO_CYCLES))
    ) u_ack_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(tmo_load),
        .load_val_in(tmo_val),
        .frame_tx_in(frame_tx_in),
        .ack_rx_in(ack_rx_in),
        .expired_out(ack_expired_out),
        .tmo_out()
    );

    // =========================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    reset_idle_a: assert property (disable iff (1'b0)
        rst_in |=> r.st == state_idle_unlinked)
        else $error("not idle after reset");
    idle_close_a: assert property ((r.st != state_idle_unlinked)
        ##1 (r.st == state_idle_unlinked) |-> r.close_pend)
        else $error("no close pending on return to idle");
    idle_refuse_a: assert property (take
        && (r.st == state_idle_unlinked) && (req_kind_in == req_send)
        |=> req_reject_out && !req_accept_out)
        else $error("send not refused while idle");
    listen_enter_a: assert property (take
        && (r.st == state_idle_unlinked) && (req_kind_in == req_listen)
        |=> r.st == state_passive_wait ##1 op_code_out == op_socket)
        else $error("listen did not start passive open");
    connect_enter_a: assert property (take
        && (r.st == state_idle_unlinked) && (req_kind_in == req_connect)
        |=> r.st == state_active_open)
        else $error("connect did not enter connecting");
    accept_up_a: assert property (r.busy && (r.op == op_accept)
        && op_ack_in && op_ok_in && !r.go_active
        |=> link_up_out && (r.st == state_linked))
        else $error("accept success missed link up");
    connect_fail_a: assert property (r.busy && (r.op == op_connect)
        && op_ack_in && !op_ok_in && !remote_close_in
        |=> link_down_out ##1 op_code_out == op_close)
        else $error("connect failure missed link down");
    teardown_a: assert property (take && !remote_close_in
        && (r.st == state_linked) && (req_kind_in == req_disc)
        |=> (r.st == state_teardown) ##1 op_code_out == op_shutdown)
        else $error("teardown did not shut down");
    remote_close_a: assert property (remote_close_in
        && (r.st == state_linked) |=> r.st == state_idle_unlinked)
        else $error("remote close ignored");
    recv_fail_a: assert property ((r.st == state_teardown) && r.busy
        && (r.op == op_recv) && op_ack_in && !op_ok_in
        |=> link_down_out && (r.st == state_idle_unlinked))
        else $error("teardown recv failure missed link down");
    nexus_abort_a: assert property (login_sent_abort_in
        |=> nexus_loss_out)
        else $error("abort login raised no nexus loss");

    link_up_c: cover property (link_up_out ##[1:50] r.st == state_teardown);
    rx_char_c: cover property (rx_valid_out && !rx_ready_in
        ##1 !buf_rdy);
    relisten_c: cover property (r.go_active ##[1:20]
        r.st == state_active_open);

endmodule : network_transport_port

// >>> sock_engine.sv
// socket engine model standing in for the tcp/ip stack
`timescale 1ns/100ps
module sock_engine (
    input logic clk_in,
    input logic rst_in,
    input logic op_req_in,
    input conn_pkg::sock_op_t op_code_in,
    input logic cancel_in,
    input logic go_in,
    input logic ok_in,
    output logic ack_out,
    output logic ok_out,
    output logic [7:0] rdata_out
);
    import conn_pkg::*;
    logic [1:0] wait_r;
    logic cancel_r;
    logic park;
    // accept and connect wait for the far side unless cancelled
    assign park = (op_code_in == op_accept || op_code_in == op_connect) &&
        !go_in && !cancel_r;
    // one ack pulse ends each op; result lines toggle every cycle except on the ack
    always_ff @(posedge clk_in) begin
        ack_out <= 1'h0;
        ok_out <= !ok_out;
        rdata_out <= ~rdata_out;
        if (rst_in) begin
            wait_r <= 2'h0;
            cancel_r <= 1'h0;
            ok_out <= 1'h0;
            rdata_out <= 8'h00;
        end else begin
            if (cancel_in)
                cancel_r <= 1'h1;
            if (op_req_in && !ack_out && !park) begin
                wait_r <= wait_r + 2'h1;
                if (wait_r == 2'h3) begin
                    ack_out <= 1'h1;
                    ok_out <= ok_in && !cancel_r;
                    rdata_out <= 8'h3c;
                    cancel_r <= 1'h0;
                end
            end
        end
    end
endmodule : sock_engine

// >>> network_transport_port_tb_top.sv
// bench for the network transport port connection machine
`timescale 1ns/100ps
module network_transport_port_tb_top;
    import conn_pkg::*;
    logic clk_in, rst_in, req_valid_in, rx_ready_in, presence_in, go, ok;
    logic req_ready_out, req_accept_out, req_reject_out, link_up_out;
    logic link_down_out, rx_valid_out, op_req_out, op_cancel_out, op_ack_in;
    logic op_ok_in, remote_reject_out, nexus_loss_out, ack_expired_out;
    logic [7:0] req_char_in, rx_char_out, op_data_out, op_rdata_in;
    logic [9:0] ev;
    logic [1:0] got;
    upper_req_t req_kind_in;
    sock_op_t op_code_out;
    conn_state_t state_out;
    int num_errors, n_compared, ups, downs, nex, exps, rej, closes;
    // short time-out keeps the timer scenario brief
    network_transport_port #(.ACK_TMO_CYCLES(20)) dut (.clk_in, .rst_in,
        .req_valid_in, .req_kind_in, .req_char_in, .req_ready_out,
        .req_accept_out, .req_reject_out, .link_up_out, .link_down_out,
        .rx_valid_out, .rx_ready_in, .rx_char_out, .op_req_out, .op_code_out,
        .op_data_out, .op_cancel_out, .op_ack_in, .op_ok_in, .op_rdata_in,
        .remote_close_in(ev[7]), .remote_conn_in(ev[8]), .remote_reject_out,
        .login_sent_abort_in(ev[0]), .login_rcvd_abort_in(ev[1]),
        .reset_unit_ack_in(ev[2]), .presence_in, .reset_line_in(ev[3]),
        .nexus_loss_out, .param_change_in(ev[5]), .param_tmo_in(32'h0000_000a),
        .tmo_unit_in(ev[6]), .tmo_unit_val_in(32'h0000_000a),
        .frame_tx_in(ev[4]), .ack_rx_in(ev[9]), .ack_expired_out, .state_out);
    sock_engine eng (.clk_in, .rst_in, .op_req_in(op_req_out),
        .op_code_in(op_code_out), .cancel_in(op_cancel_out), .go_in(go),
        .ok_in(ok), .ack_out(op_ack_in), .ok_out(op_ok_in),
        .rdata_out(op_rdata_in));
    // ========
    // clock, pulse tallies and a watchdog far beyond the expected run
    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        ups += link_up_out;
        downs += link_down_out;
        nex += nexus_loss_out;
        exps += ack_expired_out;
        rej += remote_reject_out;
        closes += op_ack_in && op_code_out == op_close;
    end
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
    // ========
    // shared helpers
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        num_errors += (seen !== exp);
        if (seen !== exp)
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    // bounded wait, then two more cycles so tallies have landed
    task until_st(input conn_state_t s);
        for (int i = 0; i < 300 && state_out !== s; i++)
            @(negedge clk_in);
        cyc(2);
    endtask : until_st
    // request held until taken; got holds accept and reject a cycle later
    task req(input upper_req_t k);
        @(posedge clk_in);
        req_kind_in <= k;
        req_char_in <= 8'ha5;
        req_valid_in <= 1'h1;
        @(negedge clk_in);
        for (int i = 0; i < 300 && req_ready_out !== 1'h1; i++)
            @(negedge clk_in);
        @(posedge clk_in);
        req_valid_in <= 1'h0;
        @(negedge clk_in);
        got = {req_accept_out, req_reject_out};
    endtask : req
    task pulse(input int b);
        @(posedge clk_in);
        ev[b] <= 1'h1;
        @(posedge clk_in);
        ev[b] <= 1'h0;
        cyc(3);
    endtask : pulse
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // ========
    // scenarios
    task t_idle;
        req(req_send);
        chk(got, 2'h1);
        req(req_disc);
        chk(got, 2'h1);
        pulse(8);
        chk(rej, 1);
    endtask : t_idle
    task t_listen;
        req(req_listen);
        chk(got, 2'h2);
        until_st(state_passive_wait);
        cyc(30);
        chk(op_code_out, op_accept);
        req(req_send);
        chk(got, 2'h1);
        @(posedge clk_in) go <= 1'h1;
        until_st(state_linked);
        chk(ups, 1);
    endtask : t_listen
    task t_linked;
        req(req_send);
        chk(got, 2'h2);
        cyc(1);
        chk({op_code_out, op_data_out}, {op_send, 8'ha5});
        req(req_connect);
        chk(got, 2'h1);
        req(req_recv);
        for (int i = 0; i < 50 && rx_valid_out !== 1'h1; i++)
            @(negedge clk_in);
        chk(rx_char_out, 8'h3c);
    endtask : t_linked
    task t_down;
        req(req_disc);
        chk(got, 2'h2);
        until_st(state_teardown);
        chk(state_out, state_teardown);
        req(req_send);
        chk(got, 2'h1);
        req(req_recv);
        chk(got, 2'h2);
        @(posedge clk_in) ok <= 1'h0;
        until_st(state_idle_unlinked);
        chk(downs, 1);
        @(posedge clk_in) ok <= 1'h1;
    endtask : t_down
    task t_connect;
        req(req_connect);
        chk(got, 2'h2);
        until_st(state_linked);
        chk(ups, 2);
        pulse(7);
        chk(state_out, state_idle_unlinked);
        cyc(20);
        chk(closes, 2);
    endtask : t_connect
    task t_cancel;
        @(posedge clk_in) go <= 1'h0;
        req(req_listen);
        until_st(state_passive_wait);
        req(req_disc);
        until_st(state_idle_unlinked);
        req(req_listen);
        until_st(state_passive_wait);
        req(req_connect);
        chk(got, 2'h2);
        until_st(state_active_open);
        chk(state_out, state_active_open);
        chk(op_code_out, op_socket);
        req(req_listen);
        chk(got, 2'h1);
        req(req_disc);
        until_st(state_idle_unlinked);
        chk(downs, 3);
    endtask : t_cancel
    task t_events;
        for (int b = 0; b < 4; b++) begin
            pulse(b);
            cyc(4);
            chk(nex, b + 1);
        end
        @(posedge clk_in) presence_in <= 1'h0;
        cyc(8);
        chk(nex, 5);
        pulse(4);
        cyc(12);
        chk(exps, 0);
        cyc(10);
        chk(exps, 1);
        pulse(5);
        pulse(4);
        cyc(12);
        chk(exps, 2);
    endtask : t_events
    initial begin
        {req_valid_in, go, ev, req_char_in} = 20'h00000;
        {rst_in, rx_ready_in, presence_in, ok} = 4'hf;
        req_kind_in = req_listen;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'h0;
        @(negedge clk_in);
        chk(state_out, state_idle_unlinked);
        t_idle();
        t_listen();
        t_linked();
        t_down();
        t_connect();
        t_cancel();
        t_events();
        end_sim();
    end
endmodule : network_transport_port_tb_top
